// [design/pmic_flags_pkg.sv]
// Purpose: shared constants and carriers for the event and status flags
// Assumes: 8-bit register port behind the serial register interface
// Notes: register offsets are byte addresses of the serial register map
package pmic_flags_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_CTRL_OFF = 8'h18;
   localparam logic [7:0] RESET_EVENT_OFF = 8'h1a;
   localparam logic [7:0] CONV_EVENT_OFF = 8'h1b;
   localparam logic [7:0] LINREG_EVENT_OFF = 8'h1c;
   localparam logic [7:0] STATUS_OFF = 8'h1d;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SOFTWARE_RESET_REQUEST_BIT = 0;
   localparam int RESET_FLAG_BIT = 0;
   localparam int PG1_BIT = 6;
   localparam int SC1_BIT = 5;
   localparam int ILIM1_BIT = 4;
   localparam int PG0_BIT = 2;
   localparam int SC0_BIT = 1;
   localparam int ILIM0_BIT = 0;
   localparam int STAT_POWER_GOOD_OUTPUT_BIT = 7;
   localparam int STAT_CLK_BIT = 4;
   localparam int STAT_TSD_BIT = 3;
   localparam int STAT_TWARN_BIT = 2;
   localparam int STAT_OVP_BIT = 1;

   // ------------------------------------------------------------
   // masks and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_FLAG_MASK = 8'h01;
   localparam logic [7:0] EVENT_MASK = 8'h77;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] READ_NONE = 8'h00;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int SHORT_TIME_US = 1000;
   localparam int SHORT_CYCLES = SHORT_TIME_US * CLK_MHZ;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   // raw detector conditions of one regulator
   typedef struct packed {
      logic power_good_event;
      logic output_below_short;
      logic current_limit_active;
   } reg_cond_t;

   // raw device-wide conditions
   typedef struct packed {
      logic power_good_output;
      logic external_clock_invalid;
      logic thermal_shutdown;
      logic thermal_warning;
      logic input_overvoltage;
   } glob_cond_t;

endpackage : pmic_flags_pkg

// [design/pmic_event_status_flags.sv]
// Purpose: latched event flags and live status of a power-management device
// Assumes: single clock, reset synchronous active high, detector inputs async
// Notes: regulator index 0 conv0, 1 conv1, 2 linreg0, 3 linreg1
// Contract
// - reset flag on undervoltage or software reset
// - reset event disables regulators, defaults, restarts; here no regulator disable exists, only flags to defaults and a restart_q pulse
// - reset flag holds until host writes one
// - converter1 power-good event latches bit 6
// - converter0 power-good event latches bit 2
// - converter1 short over 1 ms latches bit 5
// - converter0 short over 1 ms latches bit 1
// - converter1 current limit latches bit 4
// - converter0 current limit latches bit 0
// - linreg1 power-good event latches bit 6
// - linreg0 power-good event latches bit 2
// - linreg1 short over 1 ms latches bit 5
// - linreg0 short over 1 ms latches bit 1
// - linreg1 current limit latches bit 4
// - linreg0 current limit latches bit 0
// - status bit 7 shows power-good output
// - status bit 4 shows external clock invalid
// - status bit 3 shows thermal shutdown
// - status bit 2 shows thermal warning
// - status bit 1 shows input overvoltage
// - converter summary follows converter event register
// - linreg summary follows linreg event register
// - software reset request resets, reloads, self-clears
`timescale 1ns/100ps

module pmic_event_status_flags #(
   parameter int unsigned SHORT_CYCLES = pmic_flags_pkg::SHORT_CYCLES,
   parameter int CNT_W = 16,
   parameter int NREG = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   input wire logic analog_supply_low,
   input wire pmic_flags_pkg::reg_cond_t [NREG-1:0] reg_cond,
   input wire pmic_flags_pkg::glob_cond_t glob_cond,
   output logic converter_summary_q,
   output logic linreg_summary_flag_q,
   output logic restart_q,
   output logic nvm_reload_q,
   output logic serial_reset_q
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // write-one-to-clear with set winning over the clear
   function automatic logic [7:0] w1c(input logic [7:0] q,
                                      input logic [7:0] set,
                                      input logic clr_en,
                                      input logic [7:0] clr,
                                      input logic [7:0] mask);
      logic [7:0] c;
      c = clr_en ? clr : 8'h00;
      w1c = ((q & ~c) | set) & mask;
   endfunction : w1c

   localparam int RAW_W = 1 + $bits(pmic_flags_pkg::glob_cond_t)
                        + NREG * $bits(pmic_flags_pkg::reg_cond_t);
   localparam logic [CNT_W-1:0] SHORT_LIMIT = CNT_W'(SHORT_CYCLES);

   // ------------------------------------------------------------
   // input synchroniser
   // ------------------------------------------------------------
   logic [RAW_W-1:0] sync1_q;
   logic [RAW_W-1:0] sync2_q;
   logic [RAW_W-1:0] prev_q;
   logic uv_now;
   logic uv_prev;
   pmic_flags_pkg::glob_cond_t glob_s;
   pmic_flags_pkg::reg_cond_t [NREG-1:0] cond_s;
   pmic_flags_pkg::reg_cond_t [NREG-1:0] cond_p;

   // second stage feeds everything; first stage is read only here
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
      end else begin
         sync1_q <= {analog_supply_low, glob_cond, reg_cond};
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   assign {uv_now, glob_s, cond_s} = sync2_q;
   assign {uv_prev, cond_p} = {prev_q[RAW_W-1], prev_q[NREG*3-1:0]};

   // ------------------------------------------------------------
   // reset event
   // ------------------------------------------------------------
   logic uv_rise;
   logic sw_req;
   logic reset_event;

   assign uv_rise = uv_now & ~uv_prev;
   assign sw_req = reg_wr && hit(reg_addr, pmic_flags_pkg::RESET_CTRL_OFF)
                   && reg_wdata[pmic_flags_pkg::SOFTWARE_RESET_REQUEST_BIT];
   assign reset_event = uv_rise | sw_req;

   // one-cycle pulses; the request bit itself never stores a one
   always_ff @(posedge clk) begin
      if (srst) begin
         restart_q <= 1'b0;
         nvm_reload_q <= 1'b0;
         serial_reset_q <= 1'b0;
      end else begin
         restart_q <= reset_event;
         nvm_reload_q <= sw_req;
         serial_reset_q <= sw_req;
      end
   end

   // ------------------------------------------------------------
   // per-regulator event detection
   // ------------------------------------------------------------
   logic [CNT_W-1:0] short_cnt_q [NREG];
   logic [2:0] ev [NREG];

   generate
      for (genvar i = 0; i < NREG; i++) begin : g_reg
         // saturating count of consecutive cycles below short level
         always_ff @(posedge clk) begin
            if (srst || reset_event || !cond_s[i].output_below_short) begin
               short_cnt_q[i] <= '0;
            end else if (short_cnt_q[i] != SHORT_LIMIT) begin
               short_cnt_q[i] <= short_cnt_q[i] + 1'b1;
            end
         end
         // pg on a detector edge, short past the limit, ilim on level
         assign ev[i] = {cond_s[i].power_good_event
                         & ~cond_p[i].power_good_event,
                         cond_s[i].output_below_short
                         && short_cnt_q[i] == SHORT_LIMIT,
                         cond_s[i].current_limit_active};
      end
   endgenerate

   // ------------------------------------------------------------
   // event flag registers
   // ------------------------------------------------------------
   logic [7:0] rst_flag_q;
   logic [7:0] conv_q;
   logic [7:0] lin_q;
   logic [7:0] conv_set;
   logic [7:0] lin_set;
   logic [7:0] conv_d;
   logic [7:0] lin_d;
   logic wr_rst;
   logic wr_conv;
   logic wr_lin;

   function automatic logic [7:0] place(input logic [2:0] hi,
                                        input logic [2:0] lo);
      logic [7:0] v;
      v = 8'h00;
      v[pmic_flags_pkg::PG1_BIT] = hi[2];
      v[pmic_flags_pkg::SC1_BIT] = hi[1];
      v[pmic_flags_pkg::ILIM1_BIT] = hi[0];
      v[pmic_flags_pkg::PG0_BIT] = lo[2];
      v[pmic_flags_pkg::SC0_BIT] = lo[1];
      v[pmic_flags_pkg::ILIM0_BIT] = lo[0];
      place = v;
   endfunction : place

   assign conv_set = place(ev[1], ev[0]);
   assign lin_set = place(ev[3], ev[2]);
   assign wr_rst = reg_wr && hit(reg_addr, pmic_flags_pkg::RESET_EVENT_OFF);
   assign wr_conv = reg_wr && hit(reg_addr, pmic_flags_pkg::CONV_EVENT_OFF);
   assign wr_lin = reg_wr && hit(reg_addr, pmic_flags_pkg::LINREG_EVENT_OFF);
   assign conv_d = reset_event ? pmic_flags_pkg::FLAGS_RESET
                 : w1c(conv_q, conv_set, wr_conv, reg_wdata,
                       pmic_flags_pkg::EVENT_MASK);
   assign lin_d = reset_event ? pmic_flags_pkg::FLAGS_RESET
                : w1c(lin_q, lin_set, wr_lin, reg_wdata,
                      pmic_flags_pkg::EVENT_MASK);

   always_ff @(posedge clk) begin
      if (srst) begin
         rst_flag_q <= pmic_flags_pkg::FLAGS_RESET;
      end else begin
         rst_flag_q <= w1c(rst_flag_q, {7'h00, reset_event}, wr_rst,
                           reg_wdata, pmic_flags_pkg::RESET_FLAG_MASK);
      end
   end

   // a reset event wipes the regulator flags back to defaults
   always_ff @(posedge clk) begin
      if (srst) begin
         conv_q <= pmic_flags_pkg::FLAGS_RESET;
         lin_q <= pmic_flags_pkg::FLAGS_RESET;
      end else begin
         conv_q <= conv_d;
         lin_q <= lin_d;
      end
   end

   // summaries track the next value so they drop with the last clear
   always_ff @(posedge clk) begin
      if (srst) begin
         converter_summary_q <= 1'b0;
         linreg_summary_flag_q <= 1'b0;
      end else begin
         converter_summary_q <= |conv_d;
         linreg_summary_flag_q <= |lin_d;
      end
   end

   // ------------------------------------------------------------
   // status and read port
   // ------------------------------------------------------------
   logic [7:0] stat_w;

   always_comb begin
      stat_w = 8'h00;
      stat_w[pmic_flags_pkg::STAT_POWER_GOOD_OUTPUT_BIT] = glob_s.power_good_output;
      stat_w[pmic_flags_pkg::STAT_CLK_BIT] =
         glob_s.external_clock_invalid;
      stat_w[pmic_flags_pkg::STAT_TSD_BIT] = glob_s.thermal_shutdown;
      stat_w[pmic_flags_pkg::STAT_TWARN_BIT] = glob_s.thermal_warning;
      stat_w[pmic_flags_pkg::STAT_OVP_BIT] = glob_s.input_overvoltage;
   end

   // unmapped offsets and the self-clearing request read as zero
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata_q <= pmic_flags_pkg::READ_NONE;
      end else if (reg_rd) begin
         unique case (reg_addr)
            pmic_flags_pkg::RESET_EVENT_OFF: reg_rdata_q <= rst_flag_q;
            pmic_flags_pkg::CONV_EVENT_OFF: reg_rdata_q <= conv_q;
            pmic_flags_pkg::LINREG_EVENT_OFF: reg_rdata_q <= lin_q;
            pmic_flags_pkg::STATUS_OFF: reg_rdata_q <= stat_w;
            default: reg_rdata_q <= pmic_flags_pkg::READ_NONE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_uv_edge;
      $past(analog_supply_low, 2) && !$past(analog_supply_low, 3);
   endsequence

   sequence s_sw_write;
      reg_wr && reg_addr == pmic_flags_pkg::RESET_CTRL_OFF
      && reg_wdata[pmic_flags_pkg::SOFTWARE_RESET_REQUEST_BIT];
   endsequence

   sequence s_conv_zero_write;
      reg_wr && reg_addr == pmic_flags_pkg::CONV_EVENT_OFF
      && reg_wdata == 8'h00 && !reset_event;
   endsequence

   AST_RESET_FLAG_SET: assert property (
      s_sw_write |=> rst_flag_q[pmic_flags_pkg::RESET_FLAG_BIT]
   ) else $error("reset flag not set by software reset");

   AST_UV_SYNCED: assert property (
      uv_rise |-> s_uv_edge
   ) else $error("undervoltage edge not two cycles old");

   AST_RESTART_DEFAULTS: assert property (
      reset_event |=> restart_q && conv_q == 8'h00 && lin_q == 8'h00
   ) else $error("reset event did not restart with defaults");

   AST_RESET_FLAG_HOLD: assert property (
      rst_flag_q[pmic_flags_pkg::RESET_FLAG_BIT]
      && !(wr_rst && reg_wdata[pmic_flags_pkg::RESET_FLAG_BIT])
      |=> rst_flag_q[pmic_flags_pkg::RESET_FLAG_BIT]
   ) else $error("reset flag dropped without a clear");

   AST_RESET_FLAG_CLEAR: assert property (
      wr_rst && reg_wdata[pmic_flags_pkg::RESET_FLAG_BIT] && !reset_event
      |=> !rst_flag_q[pmic_flags_pkg::RESET_FLAG_BIT]
   ) else $error("reset flag not cleared by written one");

   AST_CONV_LATCH: assert property (
      !reset_event |=> (conv_q & $past(conv_set)) == $past(conv_set)
   ) else $error("converter event not latched");

   AST_LIN_LATCH: assert property (
      !reset_event |=> (lin_q & $past(lin_set)) == $past(lin_set)
   ) else $error("linear regulator event not latched");

   AST_SHORT_TIME: assert property (
      $rose(conv_q[pmic_flags_pkg::SC0_BIT])
      |-> $past(short_cnt_q[0]) == SHORT_LIMIT
   ) else $error("short flag set before the filter time");

   AST_SHORT_TIME_LIN: assert property (
      $rose(lin_q[pmic_flags_pkg::SC1_BIT])
      |-> $past(short_cnt_q[3]) == SHORT_LIMIT
   ) else $error("linreg short flag set before the filter time");

   AST_STATUS_READ: assert property (
      reg_rd && reg_addr == pmic_flags_pkg::STATUS_OFF
      |=> reg_rdata_q == $past(stat_w)
   ) else $error("status read does not show live conditions");

   AST_SUMMARY: assert property (
      ##1 converter_summary_q == (conv_q != 8'h00)
      && linreg_summary_flag_q == (lin_q != 8'h00)
   ) else $error("summary flag out of step with event register");

   AST_SW_SELF_CLEAR: assert property (
      s_sw_write ##1 !sw_req
      |-> nvm_reload_q && serial_reset_q ##1 !nvm_reload_q && !serial_reset_q
   ) else $error("software reset request did not self-clear");

   AST_ZERO_WRITE_KEEPS: assert property (
      s_conv_zero_write |=> (conv_q & $past(conv_q)) == $past(conv_q)
   ) else $error("zero write changed an event flag");

   AST_SET_BEATS_CLEAR: assert property (
      wr_conv && (reg_wdata & conv_set) != 8'h00 && !reset_event
      |=> (conv_q & $past(conv_set)) == $past(conv_set)
   ) else $error("clear won over a simultaneous set");

   AST_RESERVED_ZERO: assert property (
      (conv_q & ~pmic_flags_pkg::EVENT_MASK) == 8'h00
      && (lin_q & ~pmic_flags_pkg::EVENT_MASK) == 8'h00
      && (rst_flag_q & ~pmic_flags_pkg::RESET_FLAG_MASK) == 8'h00
   ) else $error("reserved bit set");

endmodule : pmic_event_status_flags

// [tb/host_port_model.sv]
// Purpose: host side of the byte register port, one transfer at a time
// Assumes: strobes launched on the falling edge, taken on the next rising
// Notes: address and data are scrambled while no strobe qualifies them
`timescale 1ns/100ps

module host_port_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata_q
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end

   // idle bus shows the inverse so stale values never look valid
   task automatic release_bus();
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask : release_bus

   // a written one acknowledges a flag, zeros leave it alone
   task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      reg_addr = addr;
      reg_wdata = data;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      release_bus();
   endtask : write_byte

   task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk);
      reg_addr = addr;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      data = reg_rdata_q;
      release_bus();
   endtask : read_byte
endmodule : host_port_model

// [tb/pmic_event_status_flags_tb.sv]
// Purpose: self-checking bench for the event flags and status register
// Assumes: short-circuit time shortened to SHORT cycles
// Notes: expectations come from a small integer model of the flags
`timescale 1ns/100ps

module pmic_event_status_flags_tb;
   localparam int SHORT = 20;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic [7:0] reg_wdata;
   logic reg_rd;
   logic [7:0] reg_rdata_q;
   logic analog_supply_low = 1'b0;
   logic [11:0] cond_bits = 12'h000;
   logic [4:0] glob_bits = 5'h00;
   logic converter_summary_q;
   logic linreg_summary_flag_q;
   logic restart_q;
   logic nvm_reload_q;
   logic serial_reset_q;
   int mismatches = 0;
   int n_compared = 0;
   int conv_m;
   int lin_m;
   logic [31:0] seed = 32'h0001471c;
   logic [7:0] rd;
   logic [7:0] offs [7] = '{8'h00, 8'h18, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'hff};

   always #10 clk = ~clk;

   host_port_model i_host_port_model (.clk(clk), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q));

   pmic_event_status_flags #(.SHORT_CYCLES(SHORT)) i_pmic_event_status_flags (
      .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .analog_supply_low(analog_supply_low), .reg_cond(cond_bits),
      .glob_cond(glob_bits), .converter_summary_q(converter_summary_q),
      .linreg_summary_flag_q(linreg_summary_flag_q), .restart_q(restart_q),
      .nvm_reload_q(nvm_reload_q), .serial_reset_q(serial_reset_q));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xorshift

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   task automatic finish_test();
      if (mismatches == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk8(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   task automatic chk1(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask : chk1

   task automatic rd_chk(input logic [7:0] addr, input int exp);
      i_host_port_model.read_byte(addr, rd);
      chk8($sformatf("reg %h", addr), 8'(exp), rd);
   endtask : rd_chk

   // one regulator condition: latch, stickiness, clearing, summary
   task automatic cond_case(input int r, input int k);
      logic [7:0] addr;
      int b;
      addr = (r < 2) ? 8'h1b : 8'h1c;
      b = k + ((r % 2) * 4);
      if (k == 1) begin
         cond_bits[r*3+k] = 1'b1;
         tick(SHORT / 2);
         cond_bits[r*3+k] = 1'b0;
         tick(4);
         rd_chk(addr, 0);
      end
      cond_bits[r*3+k] = 1'b1;
      tick(SHORT + 8);
      rd_chk(addr, 1 << b);
      chk1("summary", 1'b1, (r < 2) ? converter_summary_q :
           linreg_summary_flag_q);
      if (k != 1) begin
         i_host_port_model.write_byte(addr, 8'(1 << b));
         rd_chk(addr, (k == 0) ? (1 << b) : 0);
      end
      cond_bits[r*3+k] = 1'b0;
      tick(4);
      i_host_port_model.write_byte(addr, 8'h00);
      rd_chk(addr, (k == 2) ? 0 : (1 << b));
      i_host_port_model.write_byte(addr, 8'(8'h88 | (1 << b)));
      rd_chk(addr, 0);
      chk1("summary clear", 1'b0, (r < 2) ? converter_summary_q :
           linreg_summary_flag_q);
   endtask : cond_case

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int g;
      int exp_s;
      int ok;
      tick(20);
      srst = 1'b0;
      tick(1);
      for (int i = 0; i < 7; i++) begin
         rd_chk(offs[i], 0);
      end
      // live status from random detector patterns
      for (int i = 0; i < 12; i++) begin
         g = int'(xorshift() & 32'h1f);
         glob_bits = 5'(g);
         exp_s = ((g >> 4) & 1) << 7 | ((g >> 3) & 1) << 4 |
                 ((g >> 2) & 1) << 3 | ((g >> 1) & 1) << 2 | (g & 1) << 1;
         tick(4);
         rd_chk(8'h1d, exp_s);
         i_host_port_model.write_byte(8'h1d, 8'hff);
         rd_chk(8'h1d, exp_s);
      end
      for (int r = 0; r < 4; r++) begin
         for (int k = 0; k < 3; k++) begin
            cond_case(r, k);
         end
      end
      // software reset wipes events and raises the reset flag
      cond_bits[0] = 1'b1;
      cond_bits[9] = 1'b1;
      tick(4);
      cond_bits[0] = 1'b0;
      cond_bits[9] = 1'b0;
      tick(4);
      conv_m = 1;
      lin_m = 1 << 4;
      rd_chk(8'h1b, conv_m);
      rd_chk(8'h1c, lin_m);
      i_host_port_model.write_byte(8'h18, 8'h01);
      chk1("restart", 1'b1, restart_q);
      chk1("nvm reload", 1'b1, nvm_reload_q);
      chk1("serial reset", 1'b1, serial_reset_q);
      tick(1);
      chk1("restart end", 1'b0, restart_q);
      chk1("reload end", 1'b0, nvm_reload_q);
      chk1("serial end", 1'b0, serial_reset_q);
      conv_m = 0;
      lin_m = 0;
      rd_chk(8'h18, 0);
      rd_chk(8'h1a, 1);
      rd_chk(8'h1b, conv_m);
      rd_chk(8'h1c, lin_m);
      chk1("summary after reset", 1'b0, converter_summary_q);
      i_host_port_model.write_byte(8'h1a, 8'hfe);
      rd_chk(8'h1a, 1);
      i_host_port_model.write_byte(8'h1a, 8'hff);
      rd_chk(8'h1a, 0);
      // undervoltage of the analog supply, with a flag pending to be wiped
      cond_bits[3] = 1'b1;
      tick(6);
      cond_bits[3] = 1'b0;
      tick(4);
      rd_chk(8'h1b, 1 << 4);
      analog_supply_low = 1'b1;
      ok = 0;
      for (int i = 0; i < 10 && ok == 0; i++) begin
         tick(1);
         if (restart_q === 1'b1) begin
            ok = 1;
         end
      end
      chk1("undervoltage restart", 1'b1, 1'(ok));
      chk1("undervoltage reload", 1'b0, nvm_reload_q);
      analog_supply_low = 1'b0;
      if (ok == 1) begin
         tick(4);
         rd_chk(8'h1a, 1);
         rd_chk(8'h1b, 0);
         chk1("summary after uv", 1'b0, converter_summary_q);
         i_host_port_model.write_byte(8'h1a, 8'h01);
         rd_chk(8'h1a, 0);
      end
      finish_test();
   end
endmodule : pmic_event_status_flags_tb
